// file: pin_change_pkg.sv
// ---------------------------------------------------------------
// constants for the pin change detector
// ---------------------------------------------------------------
package pin_change_pkg;
  localparam int          PORT_CNT     = 4;        // ports served
  localparam int          PORT_W       = 8;        // pins per port
  localparam int          REGS_PER     = 3;        // registers per port
  localparam int          ARM_CYC      = 3;        // fill of sync chain
  // register kinds within a port group
  localparam logic [3:0]  KIND_RISE    = 4'h0;     // rise_detect_enable
  localparam logic [3:0]  KIND_FALL    = 4'h1;     // fall_detect_enable
  localparam logic [3:0]  KIND_FLAG    = 4'h2;     // change flags
  // byte offsets
  localparam logic [5:0]  OFF_PORT0    = 6'h00;    // first port group
  localparam logic [5:0]  OFF_ENABLE   = 6'h30;    // peripheral_irq_enable_reg0
  localparam logic [5:0]  OFF_REQUEST  = 6'h34;    // peripheral_irq_request_reg0
  // field positions
  localparam int          MASTER_BIT   = 0;        // change_irq_master_enable
  localparam int          SUMMARY_BIT  = 0;        // change_summary_flag
  localparam int          E_PIN        = 3;        // fifth_port_pin_three
  // implemented pins: ports A,B,C full, fifth port pin three only
  localparam logic [31:0] PIN_MASK     = 32'h08FFFFFF;
  // reset values
  localparam logic [7:0]  RST_ENABLE   = 8'h00;    // edge enables
  localparam logic [7:0]  RST_FLAGS    = 8'h00;    // change flags
  localparam logic        RST_MASTER   = 1'b0;     // master enable
  // bus handshake states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;
endpackage : pin_change_pkg

// file: pin_change_interrupt.sv
// Function
// RL1 - detect on ports A,B,C and pin E3
// RL2 - each pin enabled on its own
// RL3 - request only while master enable set
// RL4 - flags still set with master off
// RL5 - rising edge needs rise enable bit
// RL6 - falling edge needs fall enable bit
// RL7 - both enables flag either direction
// RL8 - sticky flag, interrupt when master set
// RL9 - summary flag is OR of flags
// RL10 - writing zero clears a flag
// RL11 - edge during write keeps flag set
// RL12 - software clears only observed flags
// RL13 - enabled edge wakes device from sleep; code wakes only while master enable is set
// RL14 - two-stage sync, compare with previous
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
module pin_change_interrupt #(
  parameter int ADDR_W = 6                      // byte address width
) (
  input  wire logic              clk_sys,       // system clock
  input  wire logic              nrst,          // async reset, low
  input  wire logic [ADDR_W-1:0] avs_address,   // byte address
  input  wire logic              avs_read,      // read request
  input  wire logic              avs_write,     // write request
  input  wire logic [31:0]       avs_writedata, // write data
  input  wire logic [3:0]        avs_byteenable,// byte lanes
  output logic      [31:0]       avs_readdata,  // read data
  output logic                   avs_waitrequest,// stall
  input  wire logic [7:0]        pinsA,         // first port pins
  input  wire logic [7:0]        pinsB,         // second port pins
  input  wire logic [7:0]        pinsC,         // third port pins
  input  wire logic              pinE3,         // fifth_port_pin_three
  input  wire logic              sleepMode,     // core is asleep
  output logic                   irq,           // change interrupt
  output logic                   wakeReq        // wake from sleep
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (ADDR_W < 6)
  begin : g_chk
    $error("ADDR_W must be at least 6");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [3:0][7:0]         pinsRaw;      // pins in port layout
  logic [3:0][7:0]         sync1_ff;     // first sync stage
  logic [3:0][7:0]         sync2_ff;     // second sync stage
  logic [3:0][7:0]         prev_ff;      // previous sample
  logic [2:0]              arm_ff;       // chain fill tracker
  logic [3:0][7:0]         riseEn_ff;    // rise_detect_enable
  logic [3:0][7:0]         fallEn_ff;    // fall_detect_enable
  logic [3:0][7:0]         flags_ff;     // per-pin change flags
  logic [3:0][7:0]         nxt_flags;    // next flags
  logic                    masterEn_ff;  // change_irq_master_enable
  logic [3:0][7:0]         riseHit;      // enabled rising edges
  logic [3:0][7:0]         fallHit;      // enabled falling edges
  logic [3:0][7:0]         edgeHit;      // all enabled edges
  logic                    summary;      // change_summary_flag
  logic                    wrAcc;        // write accepted this edge
  logic [3:0]              wIdx;         // word index of access
  logic                    inRange;      // address within the port groups
  logic [7:0]              rdMux;        // read value
  logic [31:0]             readData_ff;  // read data register
  logic                    waitReq_ff;   // waitrequest register
  logic                    irq_ff;       // interrupt register
  logic                    wake_ff;      // wake register
  pin_change_pkg::bus_state_t busState_ff; // handshake state

  // port number of a word index
  function automatic logic [1:0] portOf(input logic [3:0] idx);
    portOf = 2'((idx - pin_change_pkg::OFF_PORT0[5:2]) / 4'(pin_change_pkg::REGS_PER));
  endfunction : portOf

  // register kind of a word index
  function automatic logic [3:0] kindOf(input logic [3:0] idx);
    kindOf = (idx - pin_change_pkg::OFF_PORT0[5:2]) % 4'(pin_change_pkg::REGS_PER);
  endfunction : kindOf

  // implemented pins of one port
  function automatic logic [7:0] maskOf(input logic [1:0] p);
    maskOf = pin_change_pkg::PIN_MASK[p*8 +: 8];
  endfunction : maskOf

  // ---------------------------------------------------------------
  // pin capture and edge detection
  // ---------------------------------------------------------------
  // place the fifth port pin at its bit, others absent
  always_comb
  begin
    pinsRaw                               = '0;
    pinsRaw[0]                            = pinsA;
    pinsRaw[1]                            = pinsB;
    pinsRaw[2]                            = pinsC;
    pinsRaw[3][pin_change_pkg::E_PIN]     = pinE3;
  end

  // two-stage synchroniser then previous sample
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff  <= '0;
    end
    else
    begin
      sync1_ff <= pinsRaw;                        // RL14
      sync2_ff <= sync1_ff;                       // RL14
      prev_ff  <= sync2_ff;                       // RL14
    end
  end

  // ignore edges until the chain holds real samples
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      arm_ff <= '0;
    else
      arm_ff <= {arm_ff[1:0], 1'b1};
  end

  // compare current and previous samples per pin
  always_comb
  begin
    riseHit = sync2_ff & ~prev_ff & riseEn_ff;    // RL5 RL14
    fallHit = ~sync2_ff & prev_ff & fallEn_ff;    // RL6
    edgeHit = (riseHit | fallHit)                 // RL7 RL2
              & pin_change_pkg::PIN_MASK          // RL1
              & {32{arm_ff[pin_change_pkg::ARM_CYC-1]}};
  end

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  assign wIdx    = avs_address[5:2];
  assign inRange = (wIdx < 4'(pin_change_pkg::PORT_CNT * pin_change_pkg::REGS_PER));
  assign wrAcc   = avs_write & ~waitReq_ff & avs_byteenable[0];

  // one wait cycle, then a one-cycle acknowledge
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      busState_ff <= pin_change_pkg::BUS_IDLE;
      waitReq_ff  <= 1'b1;
    end
    else
    begin
      case (busState_ff)
        pin_change_pkg::BUS_IDLE:
        begin
          if (avs_read || avs_write)
          begin
            busState_ff <= pin_change_pkg::BUS_ACK;
            waitReq_ff  <= 1'b0;
          end
        end
        pin_change_pkg::BUS_ACK:
        begin
          busState_ff <= pin_change_pkg::BUS_IDLE;
          waitReq_ff  <= 1'b1;
        end
        default:
        begin
          busState_ff <= pin_change_pkg::BUS_IDLE;
          waitReq_ff  <= 1'b1;
        end
      endcase
    end
  end

  // read multiplexer, unmapped words read zero
  always_comb
  begin
    rdMux = 8'h00;
    if (inRange)
    begin
      case (kindOf(wIdx))
        pin_change_pkg::KIND_RISE: rdMux = riseEn_ff[portOf(wIdx)];
        pin_change_pkg::KIND_FALL: rdMux = fallEn_ff[portOf(wIdx)];
        pin_change_pkg::KIND_FLAG: rdMux = flags_ff[portOf(wIdx)];
        default:                   rdMux = 8'h00;
      endcase
    end
    else if (avs_address[5:0] == pin_change_pkg::OFF_ENABLE)
      rdMux[pin_change_pkg::MASTER_BIT] = masterEn_ff;
    else if (avs_address[5:0] == pin_change_pkg::OFF_REQUEST)
      rdMux[pin_change_pkg::SUMMARY_BIT] = summary;     // RL9
  end

  // capture read data during the wait cycle
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      readData_ff <= '0;
    else if (avs_read && waitReq_ff)
      readData_ff <= {24'h000000, rdMux};
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // edge enables, unimplemented pins stay zero
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      riseEn_ff <= {4{pin_change_pkg::RST_ENABLE}};
      fallEn_ff <= {4{pin_change_pkg::RST_ENABLE}};
    end
    else if (wrAcc && inRange)
    begin
      if (kindOf(wIdx) == pin_change_pkg::KIND_RISE)
        riseEn_ff[portOf(wIdx)] <= avs_writedata[7:0] & maskOf(portOf(wIdx)); // RL5
      if (kindOf(wIdx) == pin_change_pkg::KIND_FALL)
        fallEn_ff[portOf(wIdx)] <= avs_writedata[7:0] & maskOf(portOf(wIdx)); // RL6
    end
  end

  // master enable bit
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      masterEn_ff <= pin_change_pkg::RST_MASTER;
    else if (wrAcc && avs_address[5:0] == pin_change_pkg::OFF_ENABLE)
      masterEn_ff <= avs_writedata[pin_change_pkg::MASTER_BIT];
  end

  // ---------------------------------------------------------------
  // change flags
  // ---------------------------------------------------------------
  // a written zero clears, an edge in the same cycle wins
  always_comb
  begin
    nxt_flags = flags_ff;
    for (int p = 0; p < pin_change_pkg::PORT_CNT; p++)
    begin
      if (wrAcc && inRange && portOf(wIdx) == 2'(p)
          && kindOf(wIdx) == pin_change_pkg::KIND_FLAG)
        nxt_flags[p] = flags_ff[p] & avs_writedata[7:0];  // RL10 RL12
      nxt_flags[p] = nxt_flags[p] | edgeHit[p];           // RL11 RL4
    end
  end

  // sticky flags, set regardless of master enable
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      flags_ff <= {4{pin_change_pkg::RST_FLAGS}};
    else
      flags_ff <= nxt_flags;                              // RL8
  end

  assign summary = |flags_ff;                             // RL9

  // ---------------------------------------------------------------
  // interrupt and wake
  // ---------------------------------------------------------------
  // level request gated by master enable
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_ff  <= 1'b0;
      wake_ff <= 1'b0;
    end
    else
    begin
      irq_ff  <= masterEn_ff & summary;                   // RL3 RL8
      wake_ff <= sleepMode & masterEn_ff & summary;       // RL13
    end
  end

  assign avs_readdata    = readData_ff;
  assign avs_waitrequest = waitReq_ff;
  assign irq             = irq_ff;
  assign wakeReq         = wake_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_pin_scope: assert property (@(posedge clk_sys) disable iff (!nrst) // RL1
    (flags_ff & ~pin_change_pkg::PIN_MASK) == 32'h00000000)
    else $error("flag set on an unimplemented pin");

  a_flag_cause: assert property (@(posedge clk_sys) disable iff (!nrst) // RL2
    ##1 ((flags_ff & ~$past(flags_ff) & ~$past(edgeHit)) == 32'h00000000))
    else $error("flag rose without an enabled edge");

  a_master_gate: assert property (@(posedge clk_sys) disable iff (!nrst) // RL3
    !masterEn_ff ##1 !masterEn_ff |=> !irq_ff)
    else $error("interrupt raised with master enable off");

  a_nomaster_det: assert property (@(posedge clk_sys) disable iff (!nrst) // RL4
    (!masterEn_ff && edgeHit != 32'h00000000) |=> summary)
    else $error("detection stopped with master enable off");

  a_rise_detect: assert property (@(posedge clk_sys) disable iff (!nrst) // RL5
    (arm_ff[2] && (sync2_ff & ~prev_ff & riseEn_ff) != 32'h00000000)
    |=> (flags_ff & $past(sync2_ff & ~prev_ff & riseEn_ff))
        == $past(sync2_ff & ~prev_ff & riseEn_ff))
    else $error("enabled rising edge not flagged");

  a_fall_detect: assert property (@(posedge clk_sys) disable iff (!nrst) // RL6 RL7
    (arm_ff[2] && (~sync2_ff & prev_ff & fallEn_ff) != 32'h00000000)
    |=> (flags_ff & $past(~sync2_ff & prev_ff & fallEn_ff))
        == $past(~sync2_ff & prev_ff & fallEn_ff))
    else $error("enabled falling edge not flagged");

  a_irq_level: assert property (@(posedge clk_sys) disable iff (!nrst) // RL8
    (masterEn_ff && summary) |=> irq_ff ##1 (irq_ff || !$past(summary) || !$past(masterEn_ff)))
    else $error("interrupt not raised for set flag");

  a_flag_hold: assert property (@(posedge clk_sys) disable iff (!nrst) // RL8
    (flags_ff != 32'h00000000 && !avs_write) |=> (flags_ff & $past(flags_ff)) == $past(flags_ff))
    else $error("flag lost without a write");

  a_summary_or: assert property (@(posedge clk_sys) disable iff (!nrst) // RL9
    (avs_read && waitReq_ff && avs_address[5:0] == pin_change_pkg::OFF_REQUEST)
    |=> avs_readdata[0] == ($past(flags_ff) != 32'h00000000))
    else $error("summary read does not match flags");

  a_clear_zero: assert property (@(posedge clk_sys) disable iff (!nrst) // RL10
    (wrAcc && inRange && kindOf(wIdx) == pin_change_pkg::KIND_FLAG
     && avs_writedata[7:0] == 8'h00 && edgeHit[portOf(wIdx)] == 8'h00)
    |=> flags_ff[$past(portOf(wIdx))] == 8'h00)
    else $error("written zero did not clear flags");

  a_edge_wins: assert property (@(posedge clk_sys) disable iff (!nrst) // RL11
    edgeHit != 32'h00000000 |=> (flags_ff & $past(edgeHit)) == $past(edgeHit))
    else $error("edge lost during flag write");

  a_wake_req: assert property (@(posedge clk_sys) disable iff (!nrst) // RL13
    (sleepMode && masterEn_ff && summary) |=> wakeReq)
    else $error("no wake for enabled edge in sleep");

  a_sync_delay: assert property (@(posedge clk_sys) disable iff (!nrst) // RL14
    arm_ff[2] |-> sync2_ff == $past(pinsRaw, 2))
    else $error("synchroniser delay is not two cycles");

  a_bus_answer: assert property (@(posedge clk_sys) disable iff (!nrst)
    ((avs_read || avs_write) && waitReq_ff) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");

endmodule : pin_change_interrupt

// file: pin_source.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// model of the external signals on the port pins
// ---------------------------------------------------------------
module pin_source (
  input  wire logic       clk_sys,  // system clock
  input  wire logic       nrst,     // async reset, low
  output logic      [7:0] pinsA,    // first port pins
  output logic      [7:0] pinsB,    // second port pins
  output logic      [7:0] pinsC,    // third port pins
  output logic            pinE3     // fifth_port_pin_three
);
  logic [31:0] pinLvl;              // packed levels, E3 at bit 27

  // levels change only just after a rising edge
  task automatic setPins(input logic [31:0] v);
    @(posedge clk_sys);
    pinLvl <= v;
  endtask : setPins

  // pins sit low while reset is held
  initial pinLvl = 32'h00000000;
  always @(negedge nrst) pinLvl <= 32'h00000000;

  // split the packed word onto the ports
  assign pinsA = pinLvl[7:0];
  assign pinsB = pinLvl[15:8];
  assign pinsC = pinLvl[23:16];
  assign pinE3 = pinLvl[27];
endmodule : pin_source

// file: testbench.sv
`timescale 1ns/10ps
`define CHECK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin failCount++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk_sys;         // 25 MHz clock
  logic        nrst;            // reset, low
  logic [5:0]  address;         // byte address
  logic        rd;              // read request
  logic        wr;              // write request
  logic [31:0] wdata;           // write data
  logic [3:0]  byteEn;          // byte lanes
  logic [31:0] rdata;           // read data
  logic        waitReq;         // stall
  logic [7:0]  pinsA;           // pins from model
  logic [7:0]  pinsB;
  logic [7:0]  pinsC;
  logic        pinE3;
  logic        sleepMode;       // core asleep
  logic        irq;             // change interrupt
  logic        wakeReq;         // wake request
  int          failCount = 0;   // mismatches
  int          numChecks = 0;   // comparisons
  logic [7:0]  d;               // scratch read value

  // ---------------------------------------------------------------
  // instances
  // ---------------------------------------------------------------
  pin_change_interrupt u_pin_change_interrupt (.clk_sys(clk_sys), .nrst(nrst),
    .avs_address(address), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(byteEn), .avs_readdata(rdata), .avs_waitrequest(waitReq),
    .pinsA(pinsA), .pinsB(pinsB), .pinsC(pinsC), .pinE3(pinE3),
    .sleepMode(sleepMode), .irq(irq), .wakeReq(wakeReq));
  pin_source u_pin_source (.clk_sys(clk_sys), .nrst(nrst), .pinsA(pinsA),
    .pinsB(pinsB), .pinsC(pinsC), .pinE3(pinE3));

  // clock, 40 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // verdict and end of run
  task automatic stopTest();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stopTest

  // hold request until waitrequest is sampled low
  task automatic waitAccept();
    int n;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_sys);
      if (waitReq === 1'b0) break;
    end
    if (n == 20)
    begin
      failCount++;
      $display("unexpected waitrequest expected 0 seen %b", waitReq);
      stopTest();
    end
  endtask : waitAccept

  // one avalon write
  task automatic busWrite(input logic [5:0] a, input logic [7:0] v,
                          input logic [3:0] be = 4'hF);
    @(posedge clk_sys);
    wr      <= 1'b1;
    address <= a;
    wdata   <= {24'h000000, v};
    byteEn  <= be;
    waitAccept();
    wr      <= 1'b0;
  endtask : busWrite

  // one avalon read, data taken at the accepting edge
  task automatic busRead(input logic [5:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    rd      <= 1'b1;
    address <= a;
    waitAccept();
    v       = rdata[7:0];
    `CHECK("readdata upper", 24'h000000, rdata[31:8])
    rd      <= 1'b0;
  endtask : busRead

  // read a register and compare
  task automatic chk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] v;
    busRead(a, v);
    `CHECK($sformatf("reg %h", a), e, v)
  endtask : chk

  // let a fixed number of edges pass
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : settle

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    nrst = 1'b0; rd = 1'b0; wr = 1'b0; address = 6'h00;
    wdata = 32'h00000000; byteEn = 4'hF; sleepMode = 1'b0;
    settle(20);
    nrst <= 1'b1;
    settle(4);
    // reset values and an unmapped place
    for (int a = 0; a <= 6'h38; a += 4) chk(a[5:0], 8'h00);
    `CHECK("irq", 1'b0, irq)
    $display("test done: reset");
    // rising edges on every pin, master off
    for (int p = 0; p < 4; p++) busWrite(6'(p * 12), 8'hFF);
    chk(6'h24, 8'h08);
    u_pin_source.setPins(32'hFFFFFFFF);
    settle(6);
    chk(6'h08, 8'hFF);
    chk(6'h14, 8'hFF);
    chk(6'h20, 8'hFF);
    chk(6'h2C, 8'h08);
    chk(6'h34, 8'h01);
    `CHECK("irq", 1'b0, irq)
    busWrite(6'h34, 8'h00);
    chk(6'h34, 8'h01);
    busWrite(6'h08, 8'h00, 4'h0);
    chk(6'h08, 8'hFF);
    $display("test done: rise");
    // clear by writing zero
    for (int p = 0; p < 4; p++) busWrite(6'(p * 12 + 8), 8'h00);
    chk(6'h08, 8'h00);
    chk(6'h34, 8'h00);
    $display("test done: clear");
    // falls need fall enable, one pin only
    for (int p = 0; p < 4; p++) busWrite(6'(p * 12), 8'h00);
    busWrite(6'h04, 8'h04);
    u_pin_source.setPins(32'h00000000);
    settle(6);
    chk(6'h08, 8'h04);
    chk(6'h14, 8'h00);
    chk(6'h20, 8'h00);
    chk(6'h2C, 8'h00);
    $display("test done: fall");
    // master enable, both directions on pin A0
    busWrite(6'h04, 8'h05);
    busWrite(6'h00, 8'h01);
    busWrite(6'h30, 8'h01);
    chk(6'h30, 8'h01);
    settle(2);
    `CHECK("irq", 1'b1, irq)
    busRead(6'h08, d);
    busWrite(6'h08, ~d);
    settle(2);
    `CHECK("irq", 1'b0, irq)
    u_pin_source.setPins(32'h00000001);
    settle(6);
    `CHECK("irq", 1'b1, irq)
    chk(6'h08, 8'h01);
    busWrite(6'h08, 8'h00);
    u_pin_source.setPins(32'h00000000);
    settle(6);
    chk(6'h08, 8'h01);
    sleepMode <= 1'b1;
    settle(3);
    `CHECK("wakeReq", 1'b1, wakeReq)
    sleepMode <= 1'b0;
    busWrite(6'h30, 8'h00);
    settle(2);
    `CHECK("irq", 1'b0, irq)
    `CHECK("wakeReq", 1'b0, wakeReq)
    chk(6'h08, 8'h01);
    $display("test done: master");
    // edge landing on the clearing write
    busWrite(6'h08, 8'h00);
    chk(6'h08, 8'h00);
    u_pin_source.setPins(32'h00000001);
    busWrite(6'h08, 8'h00);
    settle(4);
    chk(6'h08, 8'h01);
    $display("test done: race");
    stopTest();
  end

  // overall run limit
  initial
  begin
    #2000000;
    failCount++;
    $display("unexpected run length expected end seen timeout");
    stopTest();
  end
endmodule : testbench
